// ### common/svpw_pkg.sv
// Node identifiers, verb codes, parameter words and reset values of the verb block.
package svpw_pkg;
    // ------------------------------------------------------------------
    // Node identifiers
    // ------------------------------------------------------------------
    localparam int NUM_SEL = 3;
    localparam logic [7:0] SEL_NID [NUM_SEL] = '{8'h18, 8'h26, 8'h27};
    localparam logic [7:0] SEL_SRC [NUM_SEL] = '{8'h11, 8'h24, 8'h25};
    localparam logic [7:0] NID_LINE_PIN = 8'h19;
    localparam logic [7:0] NID_HP_PIN = 8'h1c;

    // ------------------------------------------------------------------
    // Verb codes
    // ------------------------------------------------------------------
    localparam logic [11:0] V_GET_PARAM = 12'hf00;
    localparam logic [11:0] V_GET_CONN_SEL = 12'hf01;
    localparam logic [11:0] V_SET_CONN_SEL = 12'h701;
    localparam logic [11:0] V_GET_CONN_LIST = 12'hf02;
    localparam logic [11:0] V_GET_POWER = 12'hf05;
    localparam logic [11:0] V_SET_POWER = 12'h705;
    localparam logic [11:0] V_GET_PIN_CTL = 12'hf07;
    localparam logic [11:0] V_SET_PIN_CTL = 12'h707;
    localparam logic [11:0] V_GET_UNSOL = 12'hf08;
    localparam logic [11:0] V_SET_UNSOL = 12'h708;
    localparam logic [11:0] V_GET_SENSE = 12'hf09;
    localparam logic [11:0] V_GET_CFG = 12'hf1c;
    localparam logic [11:0] V_SET_CFG_B0 = 12'h71c;
    localparam logic [11:0] V_SET_CFG_B1 = 12'h71d;
    localparam logic [11:0] V_SET_CFG_B2 = 12'h71e;
    localparam logic [11:0] V_SET_CFG_B3 = 12'h71f;
    localparam logic [3:0] V_GET_AMP = 4'hb;
    localparam logic [3:0] V_SET_AMP = 4'h3;

    // ------------------------------------------------------------------
    // Parameter identifiers and fixed answers
    // ------------------------------------------------------------------
    localparam logic [7:0] P_NODE_TYPE = 8'h05;
    localparam logic [7:0] P_WIDGET_CAPS = 8'h09;
    localparam logic [7:0] P_PIN_CAPS = 8'h0c;
    localparam logic [7:0] P_CONN_LEN = 8'h0e;
    localparam logic [7:0] P_POWER_STATES = 8'h0f;
    localparam logic [7:0] P_OUT_AMP_CAPS = 8'h12;
    localparam logic [31:0] SEL_WIDGET_CAPS = 32'h0030050d;
    localparam logic [31:0] SEL_OUT_AMP_CAPS = 32'h00000000;
    localparam logic [31:0] CONN_LEN_ONE = 32'h00000001;
    localparam logic [31:0] POWER_STATES_ALL = 32'h0000000f;
    localparam logic [31:0] PIN_NODE_TYPE = 32'h00000101;
    localparam logic [31:0] LINE_WIDGET_CAPS = 32'h00400581;
    localparam logic [31:0] LINE_PIN_CAPS = 32'h00000014;
    localparam logic [31:0] LINE_CONN_ENTRY = 32'h00000018;
    localparam logic [31:0] HP_WIDGET_CAPS = 32'h0040058d;
    localparam logic [31:0] HP_PIN_CAPS = 32'h0001001c;
    localparam logic [31:0] HP_OUT_AMP_CAPS = 32'h80000000;

    // ------------------------------------------------------------------
    // Field positions, limits and reset values
    // ------------------------------------------------------------------
    localparam int AMP_OUT_BIT = 15;
    localparam int AMP_LEFT_BIT = 13;
    localparam int AMP_RIGHT_BIT = 12;
    localparam int PIN_CTL_OE_BIT = 6;
    localparam int UNSOL_EN_BIT = 7;
    localparam logic [7:0] POWER_MAX = 8'h03;
    localparam logic [7:0] AMP_RESET = 8'h80;
    localparam logic [3:0] POWER_RESET = 4'h0;
    localparam logic [7:0] CONN_SEL_RESET = 8'h00;
    localparam logic PIN_OE_RESET = 1'b0;
    localparam logic UNSOL_EN_RESET = 1'b0;
    localparam logic [5:0] UNSOL_TAG_RESET = 6'h00;
    localparam logic [31:0] CFG_RESET = 32'h01011012;

    typedef enum logic {ST_IDLE = 1'b0, ST_HOLD = 1'b1} svpw_state_t;
endpackage

// ### src/svpw_sync.sv
// Two-flop synchroniser for inputs arriving from outside the clock domain.
`timescale 1ns/10ps
module svpw_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= d;
            sync_ff <= meta_ff;
        end
    end

    assign q = sync_ff;
endmodule

// ### src/svpw_verbs.sv
// Verb handling for three selector widgets and two output pin widgets.
//
// Behaviour
// - Answer the three selector node identifiers.
// - Selector output amp caps report zero.
// - Connection index stored by set, returned by get.
// - List entry returns each selector's converter source.
// - Power set accepts codes zero to three.
// - Power answer: actual 7:4, requested 3:0.
// - Amp verbs act on output amp only.
// - Answer the line and headphone pin nodes.
// - Pin node type: unsolicited capable, function group.
// - Line pin widget capabilities fixed word.
// - Line pin caps: output and presence only.
// - Line pin list length one, entry first selector.
// - Line pin control: only output enable writable.
// - Unsolicited enable bit 7, tag 5:0.
// - Pin sense returns presence in bit 31.
// - Config default written bytewise, read whole.
// - Config default resets to jack line output.
// - Headphone pin widget capabilities fixed word.
// - Headphone pin caps fixed word.
// - Headphone output amp: mute capable only.
`timescale 1ns/10ps
module svpw_verbs
    import svpw_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link command side
    input wire logic bit_clk,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_nid,
    input wire logic [19:0] cmd_verb,
    // Link answer side
    output logic resp_valid,
    output logic [31:0] resp_data,
    output logic unsol_valid,
    output logic [31:0] unsol_data,
    // Jack pins
    input wire logic jack_sense,
    output logic line_out_enable
);
    // ------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------
    logic [30:0] sync_q;
    logic bclk_s;
    logic valid_s;
    logic presence_s;
    logic [7:0] nid_s;
    logic [19:0] verb_s;
    logic bclk_d_ff;
    logic bclk_rise;

    // The framer holds the command fields steady while cmd_valid is high,
    // so a plain per-bit synchroniser cannot tear a word.
    svpw_sync #(.W(31)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({bit_clk, cmd_valid, jack_sense, cmd_nid, cmd_verb}),
        .q(sync_q)
    );

    assign bclk_s = sync_q[30];
    assign valid_s = sync_q[29];
    assign presence_s = sync_q[28];
    assign nid_s = sync_q[27:20];
    assign verb_s = sync_q[19:0];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bclk_d_ff <= 1'b0;
        end else begin
            bclk_d_ff <= bclk_s;
        end
    end

    assign bclk_rise = bclk_s & ~bclk_d_ff;

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    svpw_state_t state_ff;
    svpw_state_t nxt_state;
    logic take;
    logic [11:0] v12;
    logic [3:0] v4;
    logic [7:0] pay8;
    logic [15:0] pay16;
    logic pin_ctl_req;
    logic line_hit;
    logic hp_hit;
    logic [NUM_SEL-1:0] sel_hit;
    logic [31:0] sel_resp [NUM_SEL];
    logic [31:0] line_resp;
    logic [31:0] hp_resp;
    logic nxt_hit;
    logic [31:0] nxt_resp;

    assign v12 = verb_s[19:8];
    assign v4 = verb_s[19:16];
    assign pay8 = verb_s[7:0];
    assign pay16 = verb_s[15:0];
    assign pin_ctl_req = pay8[PIN_CTL_OE_BIT];
    assign take = (state_ff == ST_IDLE) && bclk_rise && valid_s;
    assign line_hit = nid_s == NID_LINE_PIN;
    assign hp_hit = nid_s == NID_HP_PIN;

    // One command per cmd_valid period; the next needs valid to drop first.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (take) begin
                    nxt_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!valid_s) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------------
    // Selector widgets
    // ------------------------------------------------------------------
    for (genvar i = 0; i < NUM_SEL; i++) begin : g_sel
        logic [7:0] conn_sel_ff;
        logic [3:0] pwr_ff;
        logic [7:0] amp_l_ff;
        logic [7:0] amp_r_ff;
        logic wr;

        assign sel_hit[i] = nid_s == SEL_NID[i];
        assign wr = take && sel_hit[i];

        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                conn_sel_ff <= CONN_SEL_RESET;
            end else if (wr && v12 == V_SET_CONN_SEL) begin
                conn_sel_ff <= pay8;
            end
        end

        // Codes above three are not power states and leave the field alone.
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                pwr_ff <= POWER_RESET;
            end else if (wr && v12 == V_SET_POWER && pay8 <= POWER_MAX) begin
                pwr_ff <= pay8[3:0];
            end
        end

        // Input amplifier sets are dropped: the selector has only an output amp.
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                amp_l_ff <= AMP_RESET;
                amp_r_ff <= AMP_RESET;
            end else if (wr && v4 == V_SET_AMP && pay16[AMP_OUT_BIT]) begin
                if (pay16[AMP_LEFT_BIT]) begin
                    amp_l_ff <= pay16[7:0];
                end
                if (pay16[AMP_RIGHT_BIT]) begin
                    amp_r_ff <= pay16[7:0];
                end
            end
        end

        always_comb begin
            sel_resp[i] = '0;
            if (v12 == V_GET_PARAM) begin
                case (pay8)
                    P_WIDGET_CAPS: sel_resp[i] = SEL_WIDGET_CAPS;
                    P_CONN_LEN: sel_resp[i] = CONN_LEN_ONE;
                    P_POWER_STATES: sel_resp[i] = POWER_STATES_ALL;
                    P_OUT_AMP_CAPS: sel_resp[i] = SEL_OUT_AMP_CAPS;
                    default: sel_resp[i] = '0;
                endcase
            end else if (v12 == V_GET_CONN_SEL) begin
                sel_resp[i] = {24'h000000, conn_sel_ff};
            end else if (v12 == V_GET_CONN_LIST) begin
                sel_resp[i] = {24'h000000, SEL_SRC[i]};
            end else if (v12 == V_GET_POWER) begin
                sel_resp[i] = {24'h000000, pwr_ff, pwr_ff};
            end else if (v4 == V_GET_AMP && pay16[AMP_OUT_BIT]) begin
                sel_resp[i] = {24'h000000,
                    pay16[AMP_LEFT_BIT] ? amp_l_ff : amp_r_ff};
            end
        end
    end

    // ------------------------------------------------------------------
    // Line output pin widget
    // ------------------------------------------------------------------
    logic [3:0] line_pwr_ff;
    logic pin_oe_ff;
    logic unsol_en_ff;
    logic [5:0] unsol_tag_ff;
    logic [31:0] cfg_ff;
    logic line_wr;

    assign line_wr = take && line_hit;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            line_pwr_ff <= POWER_RESET;
        end else if (line_wr && v12 == V_SET_POWER && pay8 <= POWER_MAX) begin
            line_pwr_ff <= pay8[3:0];
        end
    end

    // Headphone and input enables are unsupported and stay zero.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_oe_ff <= PIN_OE_RESET;
        end else if (line_wr && v12 == V_SET_PIN_CTL) begin
            pin_oe_ff <= pin_ctl_req;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            unsol_en_ff <= UNSOL_EN_RESET;
            unsol_tag_ff <= UNSOL_TAG_RESET;
        end else if (line_wr && v12 == V_SET_UNSOL) begin
            unsol_en_ff <= pay8[UNSOL_EN_BIT];
            unsol_tag_ff <= pay8[5:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_ff <= CFG_RESET;
        end else if (line_wr) begin
            if (v12 == V_SET_CFG_B0) begin
                cfg_ff[7:0] <= pay8;
            end
            if (v12 == V_SET_CFG_B1) begin
                cfg_ff[15:8] <= pay8;
            end
            if (v12 == V_SET_CFG_B2) begin
                cfg_ff[23:16] <= pay8;
            end
            if (v12 == V_SET_CFG_B3) begin
                cfg_ff[31:24] <= pay8;
            end
        end
    end

    always_comb begin
        line_resp = '0;
        if (v12 == V_GET_PARAM) begin
            case (pay8)
                P_NODE_TYPE: line_resp = PIN_NODE_TYPE;
                P_WIDGET_CAPS: line_resp = LINE_WIDGET_CAPS;
                P_PIN_CAPS: line_resp = LINE_PIN_CAPS;
                P_CONN_LEN: line_resp = CONN_LEN_ONE;
                P_POWER_STATES: line_resp = POWER_STATES_ALL;
                default: line_resp = '0;
            endcase
        end else if (v12 == V_GET_CONN_LIST) begin
            line_resp = LINE_CONN_ENTRY;
        end else if (v12 == V_GET_POWER) begin
            line_resp = {24'h000000, line_pwr_ff, line_pwr_ff};
        end else if (v12 == V_GET_PIN_CTL) begin
            line_resp = {25'h0000000, pin_oe_ff, 6'h00};
        end else if (v12 == V_GET_UNSOL) begin
            line_resp = {24'h000000, unsol_en_ff, 1'b0, unsol_tag_ff};
        end else if (v12 == V_GET_SENSE) begin
            line_resp = {presence_s, 31'h00000000};
        end else if (v12 == V_GET_CFG) begin
            line_resp = cfg_ff;
        end
    end

    // ------------------------------------------------------------------
    // Headphone pin widget: parameter words only
    // ------------------------------------------------------------------
    always_comb begin
        hp_resp = '0;
        if (v12 == V_GET_PARAM) begin
            case (pay8)
                P_NODE_TYPE: hp_resp = PIN_NODE_TYPE;
                P_WIDGET_CAPS: hp_resp = HP_WIDGET_CAPS;
                P_PIN_CAPS: hp_resp = HP_PIN_CAPS;
                P_CONN_LEN: hp_resp = CONN_LEN_ONE;
                P_POWER_STATES: hp_resp = POWER_STATES_ALL;
                P_OUT_AMP_CAPS: hp_resp = HP_OUT_AMP_CAPS;
                default: hp_resp = '0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Answer path
    // ------------------------------------------------------------------
    always_comb begin
        nxt_hit = 1'b0;
        nxt_resp = '0;
        for (int k = 0; k < NUM_SEL; k++) begin
            if (sel_hit[k]) begin
                nxt_hit = 1'b1;
                nxt_resp = sel_resp[k];
            end
        end
        if (line_hit) begin
            nxt_hit = 1'b1;
            nxt_resp = line_resp;
        end
        if (hp_hit) begin
            nxt_hit = 1'b1;
            nxt_resp = hp_resp;
        end
    end

    // Foreign nodes are taken but produce no answer at all.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            resp_valid <= 1'b0;
            resp_data <= '0;
        end else if (take) begin
            resp_valid <= nxt_hit;
            resp_data <= nxt_hit ? nxt_resp : '0;
        end else if (state_ff == ST_HOLD && !valid_s) begin
            resp_valid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Presence detect and unsolicited responses
    // ------------------------------------------------------------------
    logic presence_prev_ff;
    logic presence_chg;

    assign presence_chg = presence_s != presence_prev_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            presence_prev_ff <= 1'b0;
        end else begin
            presence_prev_ff <= presence_s;
        end
    end

    // A change seen while disabled is dropped, not held back for later.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            unsol_valid <= 1'b0;
            unsol_data <= '0;
        end else begin
            unsol_valid <= presence_chg && unsol_en_ff;
            if (presence_chg && unsol_en_ff) begin
                unsol_data <= {unsol_tag_ff, 26'h0000000};
            end
        end
    end

    assign line_out_enable = pin_oe_ff;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_foreign_ignored;
        take && !nxt_hit |=> !resp_valid;
    endproperty
    a_foreign_ignored: assert property (p_foreign_ignored)
        else $error("answer given to a foreign node");

    property p_sel_amp_caps;
        take && (|sel_hit) && v12 == V_GET_PARAM && pay8 == P_OUT_AMP_CAPS
            |=> resp_valid && resp_data == SEL_OUT_AMP_CAPS;
    endproperty
    a_sel_amp_caps: assert property (p_sel_amp_caps)
        else $error("selector amp caps not zero");

    property p_conn_store;
        take && sel_hit[0] && v12 == V_SET_CONN_SEL
            |=> g_sel[0].conn_sel_ff == $past(pay8);
    endproperty
    a_conn_store: assert property (p_conn_store)
        else $error("connection index not stored");

    property p_conn_list;
        take && sel_hit[1] && v12 == V_GET_CONN_LIST
            |=> resp_data == {24'h000000, SEL_SRC[1]};
    endproperty
    a_conn_list: assert property (p_conn_list)
        else $error("wrong selector source");

    property p_power_word;
        take && line_hit && v12 == V_GET_POWER
            |=> resp_data[31:8] == 24'h000000 && resp_data[7:4] == resp_data[3:0];
    endproperty
    a_power_word: assert property (p_power_word)
        else $error("power answer malformed");

    property p_pin_oe;
        take && line_hit && v12 == V_SET_PIN_CTL
            |=> line_out_enable == $past(pin_ctl_req);
    endproperty
    a_pin_oe: assert property (p_pin_oe)
        else $error("output enable not written");

    property p_sense;
        take && line_hit && v12 == V_GET_SENSE
            |=> resp_data[30:0] == 31'h00000000 && resp_data[31] == $past(presence_s);
    endproperty
    a_sense: assert property (p_sense)
        else $error("pin sense answer wrong");

    property p_cfg_top;
        take && line_hit && v12 == V_SET_CFG_B3 |=> cfg_ff[31:24] == $past(pay8);
    endproperty
    a_cfg_top: assert property (p_cfg_top)
        else $error("config top byte not written");

    property p_unsol;
        presence_chg && unsol_en_ff
            |=> unsol_valid && unsol_data[31:26] == $past(unsol_tag_ff) ##1 !unsol_valid;
    endproperty
    a_unsol: assert property (p_unsol)
        else $error("unsolicited response missing");
endmodule

// ### tb/svpw_host.sv
// Host controller model: free-running link bit clock and one verb at a time.
`timescale 1ns/10ps
module svpw_host (
    // Clock
    input wire logic clk,
    // Link
    output logic bit_clk,
    output logic cmd_valid,
    output logic [7:0] cmd_nid,
    output logic [19:0] cmd_verb,
    input wire logic resp_valid,
    input wire logic [31:0] resp_data
);
    initial begin
        bit_clk = 1'b0;
        cmd_valid = 1'b0;
        cmd_nid = 8'h00;
        cmd_verb = 20'h00000;
        #3;
        forever #62.5 bit_clk = ~bit_clk;
    end

    // The command is held until the answer is sampled; a foreign node never answers.
    task automatic xfer(input logic [7:0] n, input logic [19:0] v,
                        output logic [31:0] d, output logic g);
        int k;
        d = 32'h0;
        g = 1'b0;
        k = 0;
        @(posedge clk);
        cmd_nid <= n;
        cmd_verb <= v;
        cmd_valid <= 1'b1;
        while (resp_valid !== 1'b1 && k < 40) begin
            @(posedge clk);
            k++;
        end
        g = (resp_valid === 1'b1);
        d = resp_data;
        // Released lines show a changed pattern so stale values cannot pass.
        cmd_valid <= 1'b0;
        cmd_nid <= ~n;
        cmd_verb <= ~v;
        k = 0;
        while (resp_valid !== 1'b0 && k < 10) begin
            @(posedge clk);
            k++;
        end
        // An answer that never drops spoils the transfer, so the caller sees a mismatch.
        if (resp_valid !== 1'b0)
            g = 1'bx;
        repeat (4) @(posedge clk);
    endtask
endmodule

// ### tb/svpw_verbs_bench.sv
// Self-checking bench of the selector and pin widget verb block.
`timescale 1ns/10ps
module svpw_verbs_bench;
    import svpw_pkg::*;
    logic clk, rst_n, bit_clk, cmd_valid, resp_valid, unsol_valid, jack_sense, line_out_enable;
    logic [7:0] cmd_nid;
    logic [19:0] cmd_verb;
    logic [31:0] resp_data, unsol_data;
    int err_count, cmp_count;
    logic [7:0] sel [3] = '{8'h18, 8'h26, 8'h27};
    logic [7:0] src [3] = '{8'h11, 8'h24, 8'h25};

    svpw_host i_svpw_host (.clk(clk), .bit_clk(bit_clk), .cmd_valid(cmd_valid),
        .cmd_nid(cmd_nid), .cmd_verb(cmd_verb), .resp_valid(resp_valid),
        .resp_data(resp_data));
    svpw_verbs i_svpw_verbs (.clk(clk), .rst_n(rst_n), .bit_clk(bit_clk),
        .cmd_valid(cmd_valid), .cmd_nid(cmd_nid), .cmd_verb(cmd_verb),
        .resp_valid(resp_valid), .resp_data(resp_data), .unsol_valid(unsol_valid),
        .unsol_data(unsol_data), .jack_sense(jack_sense),
        .line_out_enable(line_out_enable));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic give_verdict;
        if (err_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask

    task automatic ask(input logic [7:0] n, input logic [19:0] v, input logic [31:0] e);
        logic [31:0] d;
        logic g;
        i_svpw_host.xfer(n, v, d, g);
        if (g !== 1'b1)
            d = 32'hxxxxxxxx;
        chk(d, e);
    endtask

    task automatic put(input logic [7:0] n, input logic [19:0] v);
        ask(n, v, 32'h0);
    endtask

    task automatic t_params;
        logic [31:0] d;
        logic g;
        for (int i = 0; i < 3; i++) begin
            ask(sel[i], {V_GET_PARAM, 8'h12}, 32'h0);
            ask(sel[i], {V_GET_CONN_LIST, 8'h00}, {24'h0, src[i]});
            ask(sel[i], {V_GET_PARAM, 8'h09}, 32'h0030050d);
            ask(sel[i], {V_GET_PARAM, 8'h0f}, 32'h0000000f);
        end
        ask(8'h18, {V_GET_PARAM, 8'h0e}, 32'h00000001);
        ask(8'h19, {V_GET_PARAM, 8'h0f}, 32'h0000000f);
        ask(8'h1c, {V_GET_PARAM, 8'h0e}, 32'h00000001);
        ask(8'h1c, {V_GET_PIN_CTL, 8'h00}, 32'h0);
        ask(8'h19, {V_GET_PARAM, 8'h05}, 32'h00000101);
        ask(8'h1c, {V_GET_PARAM, 8'h05}, 32'h00000101);
        ask(8'h19, {V_GET_PARAM, 8'h09}, 32'h00400581);
        ask(8'h19, {V_GET_PARAM, 8'h0c}, 32'h00000014);
        ask(8'h19, {V_GET_PARAM, 8'h0e}, 32'h00000001);
        ask(8'h19, {V_GET_CONN_LIST, 8'h00}, 32'h00000018);
        ask(8'h1c, {V_GET_PARAM, 8'h09}, 32'h0040058d);
        ask(8'h1c, {V_GET_PARAM, 8'h0c}, 32'h0001001c);
        ask(8'h1c, {V_GET_PARAM, 8'h12}, 32'h80000000);
        i_svpw_host.xfer(8'h17, {V_GET_PARAM, 8'h09}, d, g);
        chk({31'h0, g}, 32'h0);
    endtask

    task automatic t_conn;
        ask(8'h18, {V_GET_CONN_SEL, 8'h00}, 32'h0);
        for (int i = 0; i < 3; i++)
            put(sel[i], {V_SET_CONN_SEL, 8'h01 + 8'(i)});
        for (int i = 0; i < 3; i++)
            ask(sel[i], {V_GET_CONN_SEL, 8'h00}, 32'h01 + 32'(i));
    endtask

    task automatic t_power;
        logic [7:0] node_identifier [2];
        node_identifier = '{8'h26, 8'h19};
        ask(8'h19, {V_GET_POWER, 8'h00}, 32'h0);
        for (int i = 0; i < 2; i++) begin
            for (int c = 0; c < 4; c++) begin
                put(node_identifier[i], {V_SET_POWER, 8'(c)});
                ask(node_identifier[i], {V_GET_POWER, 8'h00}, 32'(c * 17));
            end
            put(node_identifier[i], {V_SET_POWER, 8'h04});
            ask(node_identifier[i], {V_GET_POWER, 8'h00}, 32'h33);
        end
    endtask

    task automatic t_amp;
        ask(8'h27, {V_GET_AMP, 16'ha000}, 32'h80);
        put(8'h27, {V_SET_AMP, 16'hb025});
        put(8'h27, {V_SET_AMP, 16'ha0ff});
        ask(8'h27, {V_GET_AMP, 16'ha000}, 32'hff);
        put(8'h27, {V_SET_AMP, 16'h7011});
        ask(8'h27, {V_GET_AMP, 16'h8000}, 32'h25);
        ask(8'h27, {V_GET_AMP, 16'h2000}, 32'h0);
    endtask

    task automatic t_pin;
        ask(8'h19, {V_GET_PIN_CTL, 8'h00}, 32'h0);
        put(8'h19, {V_SET_PIN_CTL, 8'hff});
        ask(8'h19, {V_GET_PIN_CTL, 8'h00}, 32'h40);
        chk({31'h0, line_out_enable}, 32'h1);
        put(8'h19, {V_SET_PIN_CTL, 8'hbf});
        chk({31'h0, line_out_enable}, 32'h0);
    endtask

    // Counts pulses over a window longer than the two-flop sync plus one register.
    task automatic jack(input logic lvl, input int want, input logic [31:0] e);
        int hits;
        hits = 0;
        jack_sense <= lvl;
        repeat (8) begin
            @(posedge clk);
            if (unsol_valid === 1'b1)
                hits++;
        end
        chk(32'(hits), 32'(want));
        if (want > 0)
            chk(unsol_data, e);
    endtask

    task automatic t_unsol;
        ask(8'h19, {V_GET_UNSOL, 8'h00}, 32'h0);
        put(8'h19, {V_SET_UNSOL, 8'hff});
        ask(8'h19, {V_GET_UNSOL, 8'h00}, 32'hbf);
        jack(1'b1, 1, 32'hfc000000);
        ask(8'h19, {V_GET_SENSE, 8'h00}, 32'h80000000);
        put(8'h19, {V_SET_UNSOL, 8'h85});
        jack(1'b0, 1, 32'h14000000);
        ask(8'h19, {V_GET_SENSE, 8'h00}, 32'h0);
        put(8'h19, {V_SET_UNSOL, 8'h05});
        jack(1'b1, 0, 32'h0);
    endtask

    task automatic t_cfg;
        ask(8'h19, {V_GET_CFG, 8'h00}, 32'h01011012);
        put(8'h19, {12'h71f, 8'h11});
        ask(8'h19, {V_GET_CFG, 8'h00}, 32'h11011012);
        put(8'h19, {12'h71c, 8'h44});
        put(8'h19, {12'h71d, 8'h33});
        put(8'h19, {12'h71e, 8'h22});
        ask(8'h19, {V_GET_CFG, 8'h00}, 32'h11223344);
    endtask

    // A second reset in mid-run must bring the config, unsolicited, amp and connection index fields back to their reset values.
    task automatic t_reset;
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        ask(8'h19, {V_GET_CFG, 8'h00}, 32'h01011012);
        ask(8'h19, {V_GET_UNSOL, 8'h00}, 32'h0);
        ask(8'h27, {V_GET_AMP, 16'ha000}, 32'h80);
        ask(8'h18, {V_GET_CONN_SEL, 8'h00}, 32'h0);
    endtask

    initial begin
        #500000;
        err_count++;
        give_verdict();
    end

    initial begin
        err_count = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        jack_sense = 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_params();
        t_conn();
        t_power();
        t_amp();
        t_pin();
        t_unsol();
        t_cfg();
        t_reset();
        give_verdict();
    end
endmodule
